// *** chpw_pkg.sv ***
/*
 * Shared constants and types of the charger host port: target address,
 * register map, field positions, reset values and timing counts.
 * Assumes a 250 MHz system clock on both ends.
 */
package chpw_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned CLK_NS = 4;
   localparam logic [6:0] TGT_ADDR = 7'h6A;
   localparam logic [7:0] REG_FIRST = 8'h02;
   localparam logic [7:0] REG_LAST = 8'h38;
   localparam logic [7:0] RD_OUTSIDE = 8'hFF;
   localparam int unsigned MEM_TOP = 56;
   localparam logic [7:0] CHARGE_CURRENT_LIMIT_LO = 8'h02;
   localparam logic [7:0] CHARGE_CURRENT_LIMIT_HI = 8'h03;
   localparam logic [7:0] CHARGE_CURRENT_LIMIT_HI_RST = 8'h01;
   localparam int unsigned CHARGE_CURRENT_LIMIT_SH = 5;
   localparam logic [7:0] CTRL_ADDR = 8'h16;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam int unsigned CTRL_REGRST = 7;
   localparam int unsigned CTRL_KICK = 2;
   localparam logic [7:0] STAT_ADDR = 8'h1D;
   localparam logic [7:0] FLAG_ADDR = 8'h20;
   localparam logic [7:0] MASK_ADDR = 8'h23;
   localparam int unsigned BIT_WD = 0;
   localparam int unsigned BIT_OT = 1;
   // Watchdog periods in seconds for codes 01, 10, 11; code 00 disables.
   localparam logic [7:0] WD_P1_S = 8'h32;
   localparam logic [7:0] WD_P2_S = 8'h64;
   localparam logic [7:0] WD_P3_S = 8'hC8;
   localparam int unsigned SEC_CYCLES = CLK_HZ;
   localparam int unsigned SEC_PER_HOUR = 3600;
   localparam int unsigned TRICKLE_H = 1;
   localparam int unsigned PRE_H = 2;
   localparam int unsigned FAST_H = 12;
   localparam int unsigned ALERT_NS = 256;
   localparam int unsigned ALERT_CYCLES = (ALERT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned START_GAP_US = 128;
   localparam int unsigned START_GAP_CYCLES = (START_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned I2C_HZ = 400_000;
   localparam int unsigned SCL_QTR_CYCLES = (CLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ);
   localparam logic [1:0] HREG_ADDR = 2'h0;
   localparam logic [1:0] HREG_WDATA = 2'h1;
   localparam logic [1:0] HREG_RDATA = 2'h2;
   localparam logic [1:0] HREG_CMD = 2'h3;
   localparam int unsigned CMD_GO = 0;
   localparam int unsigned CMD_READ = 1;
   localparam int unsigned CMD_PAIR = 2;
   localparam logic [7:0] CMD_NONE = 8'h00;

   typedef enum logic [1:0] {
      CHPW_PH_OFF     = 2'h0,
      CHPW_PH_TRICKLE = 2'h1,
      CHPW_PH_PRE     = 2'h2,
      CHPW_PH_FAST    = 2'h3
   } chpw_phase_t;
endpackage

// *** chpw_if.sv ***
/*
 * Two-wire link between the host controller and the charger target.
 * Open-drain lines with pull-ups are resolved here from the enables.
 */
`timescale 1ns/1ps
interface chpw_if;
   logic scl_host_o;
   logic scl_host_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_tgt_o;
   logic sda_tgt_oe;
   logic scl;
   logic sda;

   assign scl = !(scl_host_oe && !scl_host_o);
   assign sda = !((sda_host_oe && !sda_host_o) || (sda_tgt_oe && !sda_tgt_o));

   modport host(output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe, input scl, sda);
   modport target(output sda_tgt_o, sda_tgt_oe, input scl, sda);
endinterface

// *** chpw_target.sv ***
/*
 * Charger host port: two-wire target, register space, default/host mode
 * with watchdog, default-mode safety timers and battery-only overtemp.
 * Assumes the link and the comparator inputs are asynchronous to clk_i.
 */
`timescale 1ns/1ps
module chpw_target #(
   parameter int unsigned TICK_CYCLES = chpw_pkg::SEC_CYCLES
) (
   input  wire logic                clk_i,
   input  wire logic                srst_i,
   chpw_if.target                   bus,
   input  wire logic                batt_only_i,
   input  wire logic                die_hot_i,
   input  wire logic                die_cool_i,
   input  wire chpw_pkg::chpw_phase_t charge_phase_i,
   output logic                     charge_enable_o,
   output logic                     battery_switch_o,
   output logic [5:0]               charge_current_limit_o,
   output logic                     host_mode_o,
   output logic                     watchdog_expired_status_o,
   output logic                     host_alert_n_o
);
   import chpw_pkg::*;

   typedef enum logic [8:0] {
      T_IDLE = 9'h001, T_ADDR = 9'h002, T_ACKA = 9'h004, T_PTR = 9'h008, T_ACKP = 9'h010,
      T_WDAT = 9'h020, T_ACKW = 9'h040, T_RDAT = 9'h080, T_ACKR = 9'h100
   } chpw_tstate_t;

   function automatic logic in_map(input logic [7:0] a);
      in_map = (a >= REG_FIRST) && (a <= REG_LAST);
   endfunction

   function automatic logic [7:0] reg_default(input logic [7:0] a);
      reg_default = (a == CHARGE_CURRENT_LIMIT_HI) ? CHARGE_CURRENT_LIMIT_HI_RST : (a == CTRL_ADDR) ? CTRL_RST : 8'h00;
   endfunction

   function automatic logic [31:0] sf_limit(input chpw_phase_t p);
      unique case (p)
         CHPW_PH_TRICKLE: sf_limit = 32'(TRICKLE_H * SEC_PER_HOUR);
         CHPW_PH_PRE:     sf_limit = 32'(PRE_H * SEC_PER_HOUR);
         CHPW_PH_FAST:    sf_limit = 32'(FAST_H * SEC_PER_HOUR);
         default:         sf_limit = 32'h0;
      endcase
   endfunction

   logic [1:0] scl_sy_q, sda_sy_q;
   logic       scl_p_q, sda_p_q;
   logic [4:0] in1_q, in2_q;
   logic       scl_s, sda_s, start_w, stop_w, rise_w, fall_w;
   chpw_tstate_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, tx_q, ptr_q, rd_val;
   logic       rw_q, nack_q, oe_q;
   logic [7:0] mem_q [0:MEM_TOP];
   logic       wr_w, rd_w, regrst_w, kick_w, restart_w, expire_w;
   logic       host_mode_q, wdx_q, watchdog_event_flag_q, ot_q, ot_flag_q, bsw_q, alert_n_q;
   logic [31:0] wd_sub_q, sf_sub_q, sf_sec_q;
   logic [7:0] wd_sec_q, wd_lim;
   logic [7:0] alert_cnt_q;
   logic [5:0] charge_current_limit_half;
   logic [1:0] ph_p_q;
   logic       sf_exp_q;

   // Two flops on every asynchronous input; only the second stage is read.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         scl_sy_q <= 2'h3;
         sda_sy_q <= 2'h3;
         scl_p_q  <= 1'b1;
         sda_p_q  <= 1'b1;
         in1_q    <= 5'h00;
         in2_q    <= 5'h00;
      end else begin
         scl_sy_q <= {scl_sy_q[0], bus.scl};
         sda_sy_q <= {sda_sy_q[0], bus.sda};
         scl_p_q  <= scl_sy_q[1];
         sda_p_q  <= sda_sy_q[1];
         in1_q    <= {charge_phase_i, die_cool_i, die_hot_i, batt_only_i};
         in2_q    <= in1_q;
      end
   end

   // Oversampling at 250 MHz leaves ample margin even at 1 Mbit/s.
   assign scl_s   = scl_sy_q[1];
   assign sda_s   = sda_sy_q[1];
   assign start_w = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_w  = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign rise_w  = scl_s && !scl_p_q;
   assign fall_w  = !scl_s && scl_p_q;

   assign wr_w     = fall_w && (st_q == T_WDAT) && (cnt_q == 4'h8) && in_map(ptr_q);
   assign rd_w     = fall_w && (((st_q == T_ACKA) && rw_q) || ((st_q == T_ACKR) && !nack_q));
   assign regrst_w = wr_w && (ptr_q == CTRL_ADDR) && sh_q[CTRL_REGRST];
   assign kick_w   = wr_w && (ptr_q == CTRL_ADDR) && sh_q[CTRL_KICK];

   always_comb begin
      rd_val = mem_q[ptr_q[5:0]];
      if (!in_map(ptr_q)) begin
         rd_val = RD_OUTSIDE;
      end else if (ptr_q == STAT_ADDR) begin
         rd_val = {6'h00, ot_q, wdx_q};
      end else if (ptr_q == FLAG_ADDR) begin
         rd_val = {6'h00, ot_flag_q, watchdog_event_flag_q};
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q   <= T_IDLE;
         cnt_q  <= 4'h0;
         sh_q   <= 8'h00;
         tx_q   <= 8'h00;
         ptr_q  <= 8'h00;
         rw_q   <= 1'b0;
         nack_q <= 1'b0;
         oe_q   <= 1'b0;
      end else if (start_w) begin
         st_q  <= T_ADDR;
         cnt_q <= 4'h0;
         oe_q  <= 1'b0;
      end else if (stop_w) begin
         st_q <= T_IDLE;
         oe_q <= 1'b0;
      end else if (rise_w) begin
         if (st_q inside {T_ADDR, T_PTR, T_WDAT, T_RDAT}) begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
         end
         if (st_q == T_ACKR) begin
            nack_q <= sda_s;
         end
      end else if (fall_w) begin
         unique case (st_q)
            T_IDLE: begin
            end
            T_ADDR: if (cnt_q == 4'h8) begin
               cnt_q <= 4'h0;
               if (sh_q[7:1] == TGT_ADDR) begin
                  rw_q <= sh_q[0];
                  oe_q <= 1'b1;
                  st_q <= T_ACKA;
               end else begin
                  st_q <= T_IDLE;
               end
            end
            T_PTR: if (cnt_q == 4'h8) begin
               cnt_q <= 4'h0;
               if (in_map(sh_q)) begin
                  ptr_q <= sh_q;
                  oe_q  <= 1'b1;
                  st_q  <= T_ACKP;
               end else begin
                  st_q <= T_IDLE;
               end
            end
            T_WDAT: if (cnt_q == 4'h8) begin
               cnt_q <= 4'h0;
               ptr_q <= ptr_q + 8'h01;
               oe_q  <= in_map(ptr_q);
               st_q  <= in_map(ptr_q) ? T_ACKW : T_IDLE;
            end
            T_RDAT: begin
               if (cnt_q == 4'h8) begin
                  cnt_q <= 4'h0;
                  oe_q  <= 1'b0;
                  st_q  <= T_ACKR;
               end else begin
                  tx_q <= {tx_q[6:0], 1'b0};
                  oe_q <= !tx_q[6];
               end
            end
            T_ACKP, T_ACKW: begin
               oe_q <= 1'b0;
               st_q <= T_WDAT;
            end
            T_ACKA, T_ACKR: begin
               if (rd_w) begin
                  tx_q  <= rd_val;
                  oe_q  <= !rd_val[7];
                  ptr_q <= ptr_q + 8'h01;
                  st_q  <= T_RDAT;
               end else begin
                  oe_q <= 1'b0;
                  st_q <= rw_q ? T_IDLE : T_PTR;
               end
            end
         endcase
      end
   end

   assign bus.sda_tgt_o  = 1'b0;
   assign bus.sda_tgt_oe = oe_q;

   assign charge_current_limit_half = {mem_q[CHARGE_CURRENT_LIMIT_HI[5:0]][2:0], mem_q[CHARGE_CURRENT_LIMIT_LO[5:0]][7:5]} >> 1;

   always_ff @(posedge clk_i) begin
      if (srst_i || regrst_w) begin
         for (int i = 0; i <= MEM_TOP; i++) begin
            mem_q[i] <= reg_default(8'(i));
         end
      end else begin
         if (wr_w) begin
            mem_q[ptr_q[5:0]] <= (ptr_q == CTRL_ADDR) ? {1'b0, sh_q[6:3], 1'b0, sh_q[1:0]}
                                                      : sh_q;
         end
         if (expire_w) begin
            mem_q[CHARGE_CURRENT_LIMIT_LO[5:0]][7:5] <= charge_current_limit_half[2:0];
            mem_q[CHARGE_CURRENT_LIMIT_HI[5:0]][2:0] <= charge_current_limit_half[5:3];
            mem_q[CTRL_ADDR[5:0]]    <= CTRL_RST;
         end
      end
   end

   always_comb begin
      unique case (mem_q[CTRL_ADDR[5:0]][1:0])
         2'h1:    wd_lim = WD_P1_S;
         2'h2:    wd_lim = WD_P2_S;
         2'h3:    wd_lim = WD_P3_S;
         default: wd_lim = 8'h00;
      endcase
   end

   assign restart_w = kick_w || regrst_w || (wr_w && !host_mode_q);
   assign expire_w  = host_mode_q && (wd_lim != 8'h00) && (wd_sec_q == wd_lim - 8'h01)
                      && (wd_sub_q == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (srst_i || restart_w || !host_mode_q || wd_lim == 8'h00) begin
         wd_sub_q <= 32'h0;
         wd_sec_q <= 8'h00;
      end else if (wd_sub_q == 32'(TICK_CYCLES - 1)) begin
         wd_sub_q <= 32'h0;
         wd_sec_q <= wd_sec_q + 8'h01;
      end else begin
         wd_sub_q <= wd_sub_q + 32'h1;
      end
   end

   // Expiry outranks a write landing in the same cycle.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         host_mode_q <= 1'b0;
         wdx_q       <= 1'b1;
      end else if (expire_w) begin
         host_mode_q <= 1'b0;
         wdx_q       <= 1'b1;
      end else if (wr_w) begin
         host_mode_q <= 1'b1;
         wdx_q       <= 1'b0;
      end
   end

   // Set beats the clear-on-read when both hit the same cycle.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         watchdog_event_flag_q <= 1'b1;
         ot_flag_q <= 1'b0;
      end else begin
         if (expire_w) begin
            watchdog_event_flag_q <= 1'b1;
         end else if (rd_w && ptr_q == FLAG_ADDR) begin
            watchdog_event_flag_q <= 1'b0;
         end
         if (in2_q[0] && in2_q[1] && !ot_q) begin
            ot_flag_q <= 1'b1;
         end else if (rd_w && ptr_q == FLAG_ADDR) begin
            ot_flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         alert_cnt_q <= 8'h00;
         alert_n_q   <= 1'b1;
      end else if (expire_w && !mem_q[MASK_ADDR[5:0]][BIT_WD]) begin
         alert_cnt_q <= 8'(ALERT_CYCLES - 1);
         alert_n_q   <= 1'b0;
      end else if (alert_cnt_q != 8'h00) begin
         alert_cnt_q <= alert_cnt_q - 8'h01;
      end else begin
         alert_n_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ot_q  <= 1'b0;
         bsw_q <= 1'b1;
      end else if (in2_q[0] && in2_q[1] && !ot_q) begin
         ot_q  <= 1'b1;
         bsw_q <= 1'b0;
      end else if (ot_q && in2_q[2]) begin
         ot_q  <= 1'b0;
         bsw_q <= 1'b1;
      end
   end

   // A new phase or host mode restarts the safety timer; the buck keeps running.
   always_ff @(posedge clk_i) begin
      if (srst_i || host_mode_q || in2_q[4:3] != ph_p_q) begin
         sf_sub_q <= 32'h0;
         sf_sec_q <= 32'h0;
         sf_exp_q <= 1'b0;
         ph_p_q   <= srst_i ? 2'h0 : in2_q[4:3];
      end else if (sf_limit(chpw_phase_t'(ph_p_q)) != 32'h0 && !sf_exp_q) begin
         if (sf_sec_q == sf_limit(chpw_phase_t'(ph_p_q))) begin
            sf_exp_q <= 1'b1;
         end else if (sf_sub_q == 32'(TICK_CYCLES - 1)) begin
            sf_sub_q <= 32'h0;
            sf_sec_q <= sf_sec_q + 32'h1;
         end else begin
            sf_sub_q <= sf_sub_q + 32'h1;
         end
      end
   end

   assign charge_enable_o           = !sf_exp_q;
   assign battery_switch_o          = bsw_q;
   assign charge_current_limit_o    = {mem_q[CHARGE_CURRENT_LIMIT_HI[5:0]][2:0], mem_q[CHARGE_CURRENT_LIMIT_LO[5:0]][7:5]};
   assign host_mode_o               = host_mode_q;
   assign watchdog_expired_status_o = wdx_q;
   assign host_alert_n_o            = alert_n_q;
endmodule

// *** chpw_host.sv ***
/*
 * Host controller for the charger port: runs single-byte reads and one-
 * or two-byte writes on the two-wire link, driven from a small register
 * port. Assumes the target never stretches the clock.
 */
`timescale 1ns/1ps
module chpw_host #(
   parameter int unsigned GAP_CYCLES = chpw_pkg::START_GAP_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   chpw_if.host            bus,
   input  wire logic [1:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o
);
   import chpw_pkg::*;

   typedef enum logic [4:0] {
      H_IDLE = 5'h01, H_GAP = 5'h02, H_START = 5'h04, H_BIT = 5'h08, H_STOP = 5'h10
   } chpw_hstate_t;

   chpw_hstate_t st_q;
   logic [7:0] reg_q, wd_q, wd2_q, rx_q, rdata_q, cmd_q;
   logic [1:0] sda_sy_q, ph_q;
   logic [2:0] step_q;
   logic [3:0] bit_q;
   logic [15:0] q_cnt_q;
   logic [31:0] gap_q;
   logic       tick_w, nack_q, scl_oe_q, sda_oe_q;
   logic [7:0] txb;

   // Steps 0..5: address+W, pointer, data, address+R, read byte, second data.
   always_comb begin
      unique case (step_q)
         3'h0:    txb = {TGT_ADDR, 1'b0};
         3'h1:    txb = reg_q;
         3'h2:    txb = wd_q;
         3'h3:    txb = {TGT_ADDR, 1'b1};
         3'h5:    txb = wd2_q;
         default: txb = RD_OUTSIDE;
      endcase
   end

   assign tick_w = (q_cnt_q == 16'(SCL_QTR_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sda_sy_q <= 2'h3;
      end else begin
         sda_sy_q <= {sda_sy_q[0], bus.sda};
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg_q   <= 8'h00;
         wd_q    <= 8'h00;
         wd2_q   <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         if (wr_i && addr_i == HREG_ADDR) begin
            reg_q <= wdata_i;
         end
         if (wr_i && addr_i == HREG_WDATA) begin
            wd_q <= wdata_i;
         end
         if (wr_i && addr_i == HREG_RDATA) begin
            wd2_q <= wdata_i;
         end
         if (rd_i) begin
            unique case (addr_i)
               HREG_ADDR:  rdata_q <= reg_q;
               HREG_WDATA: rdata_q <= wd_q;
               HREG_RDATA: rdata_q <= rx_q;
               HREG_CMD:   rdata_q <= {6'h00, nack_q, st_q != H_IDLE};
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || st_q == H_IDLE || st_q == H_GAP || tick_w) begin
         q_cnt_q <= 16'h0;
      end else begin
         q_cnt_q <= q_cnt_q + 16'h1;
      end
   end

   // Counts from the last START or STOP, so both start spacing and bus-free time hold.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         gap_q <= 32'(GAP_CYCLES);
      end else if ((st_q == H_START && ph_q == 2'h2) || (st_q == H_STOP && ph_q == 2'h3)) begin
         gap_q <= 32'h0;
      end else if (gap_q < 32'(GAP_CYCLES)) begin
         gap_q <= gap_q + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q     <= H_IDLE;
         cmd_q    <= CMD_NONE;
         step_q   <= 3'h0;
         bit_q    <= 4'h0;
         ph_q     <= 2'h0;
         rx_q     <= 8'h00;
         nack_q   <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            H_IDLE: if (wr_i && addr_i == HREG_CMD && wdata_i[CMD_GO]) begin
               cmd_q  <= wdata_i;
               step_q <= 3'h0;
               nack_q <= 1'b0;
               st_q   <= H_GAP;
            end
            H_GAP: if (gap_q == 32'(GAP_CYCLES)) begin
               ph_q <= 2'h0;
               st_q <= H_START;
            end
            H_START: if (tick_w) begin
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: sda_oe_q <= 1'b0;
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: sda_oe_q <= 1'b1;
                  2'h3: begin
                     scl_oe_q <= 1'b1;
                     bit_q    <= 4'h0;
                     st_q     <= H_BIT;
                  end
               endcase
            end
            H_BIT: if (tick_w) begin
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: sda_oe_q <= (bit_q == 4'h8) ? 1'b0 : !txb[3'(4'h7 - bit_q)];
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: begin
                     if (bit_q != 4'h8) begin
                        rx_q <= {rx_q[6:0], sda_sy_q[1]};
                     end else if (step_q != 3'h4 && sda_sy_q[1]) begin
                        nack_q <= 1'b1;
                     end
                  end
                  2'h3: begin
                     scl_oe_q <= 1'b1;
                     bit_q    <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (nack_q || step_q == 3'h4 || step_q == 3'h5
                            || (step_q == 3'h2 && !cmd_q[CMD_PAIR])) begin
                           st_q <= H_STOP;
                        end else if (step_q == 3'h1 && cmd_q[CMD_READ]) begin
                           step_q <= 3'h3;
                           st_q   <= H_GAP;
                        end else begin
                           step_q <= (step_q == 3'h2) ? 3'h5 : step_q + 3'h1;
                        end
                     end
                  end
               endcase
            end
            H_STOP: if (tick_w) begin
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: sda_oe_q <= 1'b1;
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: sda_oe_q <= 1'b0;
                  2'h3: st_q <= H_IDLE;
               endcase
            end
         endcase
      end
   end

   assign bus.scl_host_o  = 1'b0;
   assign bus.scl_host_oe = scl_oe_q;
   assign bus.sda_host_o  = 1'b0;
   assign bus.sda_host_oe = sda_oe_q;
   assign rdata_o         = rdata_q;
endmodule

// *** chpw_chk.sv ***
/* Wire checker for the charger link between host and target.
   Assumes the interface resolves both open-drain lines with pull-ups. */
`timescale 1ns/1ps
module chpw_chk #(
   parameter int unsigned GAP = 200
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_tgt_o,
   input wire logic sda_tgt_oe
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic        scl_q;
   logic        sda_q;
   logic [31:0] gap_q;
   wire         start_w = scl && scl_q && sda_q && !sda;
   always_ff @(posedge clk_i) begin
      scl_q <= scl;
      sda_q <= sda;
   end
   // The first START after reset may come at once, so the count starts full.
   always_ff @(posedge clk_i) begin
      if (srst_i || start_w) gap_q <= (srst_i ? GAP : 32'h0);
      else if (gap_q < GAP) gap_q <= gap_q + 32'h1;
   end
   sequence scl_high_s; scl && $past(scl); endsequence
   sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
   a_rst_quiet: assert property (disable iff (1'b0) srst_i |=> !sda_tgt_oe)
      else $error("target drives SDA after reset");
   a_tgt_rise_low: assert property ($rose(sda_tgt_oe) |-> !scl)
      else $error("target took SDA with SCL high");
   a_tgt_fall_low: assert property ($fell(sda_tgt_oe) |-> !scl)
      else $error("target let SDA go with SCL high");
   a_tgt_stable_high: assert property (scl_high_s |-> $stable(sda_tgt_oe))
      else $error("target SDA moved in SCL high");
   a_tgt_low_value: assert property (sda_tgt_oe |-> !sda_tgt_o)
      else $error("target drives SDA high");
   a_scl_low_hold: assert property ($fell(scl) |-> !scl[*8])
      else $error("SCL low phase too short");
   a_start_gap: assert property (start_w |-> gap_q >= GAP)
      else $error("STARTs too close");
   a_stop_free: assert property (stop_s |-> !sda_tgt_oe)
      else $error("target holds SDA at STOP");
endmodule

// *** test_charger_host_port_watchdog.sv ***
/* Bench joining host and target over the link, driven via the host port.
   Assumes shortened tick and gap counts set at the instances below. */
`timescale 1ns/1ps
module test_charger_host_port_watchdog;
   import chpw_pkg::*;
   logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, bo = 0, hot = 0, cool = 1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00, rdata, got, st;
   logic en, sw, hm, wde, alert_n;
   logic [5:0] lim;
   chpw_phase_t phase = CHPW_PH_FAST;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   // Row: command bits {pair, read}, pointer, data, read data or high byte, status.
   logic [33:0] rows [3] = '{{2'h1, 8'h20, 8'h00, 8'h03, 8'h00},
      {2'h1, 8'h40, 8'h00, 8'h00, 8'h02}, {2'h2, CHARGE_CURRENT_LIMIT_LO, 8'hE0, 8'h00, 8'h00}};
   chpw_if link();
   chpw_host #(.GAP_CYCLES(200)) chpw_host_inst (.clk_i(clk_i), .srst_i(srst_i), .bus(link),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata));
   chpw_target #(.TICK_CYCLES(200)) chpw_target_inst (.clk_i(clk_i), .srst_i(srst_i),
      .bus(link), .batt_only_i(bo), .die_hot_i(hot), .die_cool_i(cool),
      .charge_phase_i(phase), .charge_enable_o(en), .battery_switch_o(sw),
      .charge_current_limit_o(lim), .host_mode_o(hm), .watchdog_expired_status_o(wde),
      .host_alert_n_o(alert_n));
   chpw_chk #(.GAP(200)) chpw_chk_inst (.clk_i(clk_i), .srst_i(srst_i), .scl(link.scl),
      .sda(link.sda), .sda_tgt_o(link.sda_tgt_o), .sda_tgt_oe(link.sda_tgt_oe));
   always #2 clk_i = ~clk_i;
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 95000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic put(input logic [1:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic get(input logic [1:0] a);
      addr <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
      got = rdata;
   endtask
   // A transfer waits on the busy bit; a hang is cut by the cycle ceiling.
   task automatic xfer(input logic [1:0] r, input logic [7:0] p, input logic [7:0] d,
                       input logic [7:0] d2);
      put(HREG_ADDR, p);
      put(HREG_WDATA, d);
      put(HREG_RDATA, d2);
      put(HREG_CMD, {5'h00, r, 1'b1});
      get(HREG_CMD);
      while (got[0] !== 1'b0) get(HREG_CMD);
      st = got;
      get(HREG_RDATA);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      chk("wd expired", 8'h01, {7'h00, wde});
      chk("host mode", 8'h00, {7'h00, hm});
      chk("limit", 8'h08, {2'h0, lim});
      chk("charging", 8'h01, {7'h00, en});
      bo <= 1'b1;
      hot <= 1'b1;
      cool <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("switch hot", 8'h00, {7'h00, sw});
      hot <= 1'b0;
      cool <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("switch cool", 8'h01, {7'h00, sw});
      foreach (rows[i]) begin
         xfer(rows[i][33:32], rows[i][31:24], rows[i][23:16], rows[i][15:8]);
         chk("status", rows[i][7:0], st);
         if (rows[i][32] && rows[i][7:0] == 8'h00) chk("data", rows[i][15:8], got);
      end
      chk("host mode", 8'h01, {7'h00, hm});
      chk("limit", 8'h07, {2'h0, lim});
      for (int i = 0; i < 6000 && alert_n !== 1'b0; i++) @(posedge clk_i);
      chk("alert", 8'h00, {7'h00, alert_n});
      repeat (2) @(posedge clk_i);
      chk("wd expired", 8'h01, {7'h00, wde});
      chk("host mode", 8'h00, {7'h00, hm});
      chk("halved", 8'h03, {2'h0, lim});
      xfer(2'h1, FLAG_ADDR, 8'h00, 8'h00);
      chk("status", 8'h00, st);
      chk("watchdog_event_flag", 8'h01, got);
      close_out();
   end
endmodule
